// *** pkg/fkl_pkg.sv ***
// package: shared constants and types of the function key logic
package fkl_pkg;

	localparam int FKL_NKEYS   = 10;          // key channels
	localparam int FKL_CLK_HZ  = 40_000_000;  // aclk rate
	localparam int FKL_DEB_MS  = 200;         // least hold before a press
	localparam int FKL_MS_CYC  = FKL_CLK_HZ / 1000;        // cycles per ms
	localparam int FKL_DEB_CYC = FKL_DEB_MS * FKL_MS_CYC;  // hold in cycles
	localparam int FKL_PLEN_W  = 16;          // pulse length field, in ms

	// register byte offsets
	localparam logic [7:0] FKL_OFF_MODE   = 8'h00;  // key_mode_setting
	localparam logic [7:0] FKL_OFF_ENABLE = 8'h04;  // key_enable_setting
	localparam logic [7:0] FKL_OFF_PEN    = 8'h08;  // pulse timer enables
	localparam logic [7:0] FKL_OFF_PLEN   = 8'h0C;  // pulse length in ms
	localparam logic [7:0] FKL_OFF_LED    = 8'h10;  // indicator colours
	localparam logic [7:0] FKL_OFF_STATE  = 8'h14;  // key_state_word
	localparam logic [7:0] FKL_OFF_INFO   = 8'h18;  // retention status
	localparam logic [7:0] FKL_ADDR_MASK  = 8'hFC;  // word alignment

	// reset values
	localparam logic [FKL_NKEYS-1:0]   FKL_MODE_RST = 10'h000;
	localparam logic [2*FKL_NKEYS-1:0] FKL_ENA_RST  = 20'h55555;
	localparam logic [FKL_NKEYS-1:0]   FKL_PEN_RST  = 10'h000;
	localparam logic [FKL_PLEN_W-1:0]  FKL_PLEN_RST = 16'h0000;
	localparam logic [2*FKL_NKEYS-1:0] FKL_LED_RST  = 20'h55555;

	localparam logic [1:0] FKL_RESP_OKAY   = 2'h0;
	localparam logic [1:0] FKL_RESP_SLVERR = 2'h2;

	// per-key enable field, code 3 behaves as disabled
	typedef enum logic [1:0] {
		FKL_DIS  = 2'h0,
		FKL_ENA  = 2'h1,
		FKL_LOCK = 2'h2
	} fkl_en_t;

	// press recogniser states
	typedef enum logic [1:0] {
		FKL_SC_IDLE  = 2'h0,
		FKL_SC_TIME  = 2'h1,
		FKL_SC_HELD  = 2'h2,
		FKL_SC_BLOCK = 2'h3
	} fkl_scan_st_t;

	// recognised key events, one-hot
	typedef struct packed {
		logic [FKL_NKEYS-1:0] press;  // one-cycle pulse on recognition
		logic [FKL_NKEYS-1:0] held;   // level while recognised and held
	} fkl_key_evt_t;

endpackage

// *** testbench/fkl_panel.sv ***
// partner model: pushbuttons and battery backed key store
`timescale 1ns/10ps
module fkl_panel (
	input  logic        aclk,
	output logic [9:0]  key_press,
	output logic        batt_ok,
	output logic [9:0]  ret_data_in,
	input  logic [9:0]  ret_data_out,
	input  logic        ret_write
);
	logic [9:0] store_q;  // battery backed copy of key states
	logic       batt_q;   // battery health

	// buttons up, battery good, empty store
	initial begin
		key_press = 10'h000;
		batt_q = 1'b1;
		store_q = 10'h000;
	end

	// store follows the design while it writes and battery holds
	always @(posedge aclk) begin
		if (ret_write && batt_q)
			store_q <= ret_data_out;
	end

	// flat battery leaves a corrupt store behind
	assign batt_ok = batt_q;
	assign ret_data_in = batt_q ? store_q : ~store_q;

	// buttons change just after a clock edge
	task automatic push(input logic [9:0] k);
		key_press <= k;
	endtask

	// battery health changes just after a clock edge
	task automatic set_batt(input logic b);
		batt_q <= b;
	endtask
endmodule

// *** testbench/tb_fkl_top.sv ***
// testbench: bus and pushbutton scenarios for the function key logic
`timescale 1ns/10ps
module tb_fkl_top;
	import fkl_pkg::*;
	logic        aclk, aresetn;     // clock, reset
	logic [7:0]  awaddr, araddr;    // bus addresses
	logic [31:0] wdata, rdata;      // bus data
	logic [3:0]  wstrb;             // byte lanes
	logic [1:0]  bresp, rresp;      // responses
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [9:0]  keys, ret_in, ret_out, slo, red, green;
	logic [9:0]  grn;               // keys whose lamp shows green too
	logic        batt_ok, ret_write;
	int          fail_count, n_compared;

	fkl_top #(.DEB_CYC(4), .MS_CYC(4)) u_fkl_top (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .key_press(keys),
		.batt_ok(batt_ok), .ret_data_in(ret_in), .ret_data_out(ret_out),
		.ret_write(ret_write), .scheme_logic_signal(slo),
		.led_red(red), .led_green(green));
	fkl_panel u_fkl_panel (
		.aclk(aclk), .key_press(keys), .batt_ok(batt_ok),
		.ret_data_in(ret_in), .ret_data_out(ret_out), .ret_write(ret_write));

	// 40 MHz clock
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	// counts and verdict, ends the run
	task automatic final_report;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// one comparison
	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask

	// a wait that ran out
	task automatic hang;
		fail_count++;
		final_report;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// bus write, response checked
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (i == 40) hang;
		bready <= 1'b0;
		chk("bresp", er, bresp);
	endtask

	// bus read, data and response checked
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (i == 40) hang;
		rready <= 1'b0;
		chk("rdata", e, rdata);
		chk("rresp", er, rresp);
	endtask

	// key outputs on the status word, the pins and the red and green lamps
	task automatic st(input logic [9:0] e);
		rd(FKL_OFF_STATE, {22'h0, e}, FKL_RESP_OKAY);
		chk("slo", {22'h0, e}, {22'h0, slo});
		chk("red", {22'h0, e}, {22'h0, red});
		chk("green", {22'h0, e & grn}, {22'h0, green});
	endtask

	// hold keys, check while held, release
	task automatic key(input logic [9:0] k, input int n,
		input logic [9:0] e);
		u_fkl_panel.push(k);
		cyc(n);
		st(e);
		u_fkl_panel.push(10'h000);
		cyc(4);
	endtask

	task automatic rst;
		aresetn <= 1'b0;
		cyc(5);
		aresetn <= 1'b1;
		cyc(4);
	endtask

	// main sequence
	initial begin
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		grn = 10'h000;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		fail_count = 0;
		n_compared = 0;
		rst;
		rd(FKL_OFF_MODE, 32'h0, FKL_RESP_OKAY);
		rd(FKL_OFF_ENABLE, 32'h55555, FKL_RESP_OKAY);
		rd(FKL_OFF_LED, 32'h55555, FKL_RESP_OKAY);
		rd(8'h1C, 32'h0, FKL_RESP_SLVERR);
		wr(8'h1C, 32'hFFFFFFFF, FKL_RESP_SLVERR);
		u_fkl_panel.push(10'h001);
		cyc(3);
		u_fkl_panel.push(10'h000);
		cyc(4);
		st(10'h000);
		key(10'h001, 6, 10'h001);
		st(10'h000);
		u_fkl_panel.push(10'h003);
		cyc(6);
		u_fkl_panel.push(10'h002);
		cyc(8);
		st(10'h000);
		u_fkl_panel.push(10'h000);
		cyc(4);
		wr(FKL_OFF_MODE, 32'h2, FKL_RESP_OKAY);
		key(10'h002, 6, 10'h002);
		key(10'h002, 6, 10'h000);
		key(10'h002, 6, 10'h002);
		wr(FKL_OFF_ENABLE, 32'h55559, FKL_RESP_OKAY);
		key(10'h002, 6, 10'h002);
		wr(FKL_OFF_ENABLE, 32'h5555A, FKL_RESP_OKAY);
		key(10'h001, 6, 10'h002);
		wr(FKL_OFF_ENABLE, 32'h5554A, FKL_RESP_OKAY);
		key(10'h004, 6, 10'h002);
		wr(FKL_OFF_STATE, 32'h0, FKL_RESP_OKAY);
		st(10'h002);
		rst;
		rd(FKL_OFF_INFO, 32'h1, FKL_RESP_OKAY);
		chk("store", 32'h2, {22'h0, ret_out});
		chk("we", 32'h1, {31'h0, ret_write});
		wr(FKL_OFF_MODE, 32'h2, FKL_RESP_OKAY);
		st(10'h002);
		u_fkl_panel.set_batt(1'b0);
		rst;
		rd(FKL_OFF_INFO, 32'h0, FKL_RESP_OKAY);
		wr(FKL_OFF_MODE, 32'h2, FKL_RESP_OKAY);
		st(10'h000);
		wr(FKL_OFF_MODE, 32'h0, FKL_RESP_OKAY);
		wr(FKL_OFF_PEN, 32'h1, FKL_RESP_OKAY);
		wr(FKL_OFF_PLEN, 32'h8, FKL_RESP_OKAY);
		wstrb <= 4'h1;
		wr(FKL_OFF_LED, 32'hFFFF_FF57, FKL_RESP_OKAY);
		wstrb <= 4'hF;
		grn <= 10'h001;
		rd(FKL_OFF_LED, 32'h55557, FKL_RESP_OKAY);
		key(10'h001, 6, 10'h001);
		rd(FKL_OFF_STATE, 32'h1, FKL_RESP_OKAY);
		chk("slo", 32'h1, {22'h0, slo});
		chk("red", 32'h0, {22'h0, red});
		cyc(30);
		st(10'h000);
		final_report;
	end
endmodule

// *** verilog/fkl_keyscan.sv ***
// module: de-glitching and single-key arbitration of the pushbuttons
`timescale 1ns/10ps
module fkl_keyscan #(
	parameter int DEB_CYC = fkl_pkg::FKL_DEB_CYC
) (
	input  logic                           aclk,
	input  logic                           aresetn,
	input  logic [fkl_pkg::FKL_NKEYS-1:0]  keys,
	output fkl_pkg::fkl_key_evt_t          evt
);
	import fkl_pkg::*;

	localparam int CW = $clog2(DEB_CYC + 1);

	// refuse hold counts the recogniser cannot serve
	if (DEB_CYC < 2) begin : g_chk
		$error("fkl_keyscan: DEB_CYC must be at least 2");
	end

	fkl_scan_st_t           st_q;    // recogniser state
	logic [FKL_NKEYS-1:0]   sel_q;   // key being timed
	logic [CW-1:0]          cnt_q;   // hold counter
	fkl_key_evt_t           evt_q;   // registered events
	logic                   one_hot; // exactly one key down
	logic                   none;    // no key down

	assign none    = (keys == '0);
	assign one_hot = !none && ((keys & (keys - 1'b1)) == '0);
	assign evt     = evt_q;

	// state, counter and events
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q  <= FKL_SC_IDLE;
			sel_q <= '0;
			cnt_q <= '0;
			evt_q <= '0;
		end else begin
			evt_q.press <= '0;
			case (st_q)
				FKL_SC_IDLE: begin
					cnt_q <= '0;
					// start timing a lone key, shut out a chord
					if (one_hot) begin
						sel_q <= keys;
						st_q  <= FKL_SC_TIME;
					end else if (!none) begin
						st_q <= FKL_SC_BLOCK; // RQ16
					end
				end
				FKL_SC_TIME: begin
					// any change aborts the glitchy press
					if (keys != sel_q) begin
						st_q <= none ? FKL_SC_IDLE : FKL_SC_BLOCK; // RQ12
					end else if (cnt_q == CW'(DEB_CYC - 2)) begin
						evt_q.press <= sel_q; // RQ13
						evt_q.held  <= sel_q;
						st_q        <= FKL_SC_HELD;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				FKL_SC_HELD: begin
					// other keys ignored while this one stays down
					if ((keys & sel_q) == '0) begin
						evt_q.held <= '0;
						st_q <= none ? FKL_SC_IDLE : FKL_SC_BLOCK; // RQ16
					end
				end
				FKL_SC_BLOCK: begin
					// wait for every key to be released
					if (none) begin
						st_q <= FKL_SC_IDLE; // RQ16
					end
				end
				default: begin
					st_q <= FKL_SC_IDLE;
				end
			endcase
		end
	end

	// checking helpers: consecutive samples of an unchanged lone key
	logic [FKL_NKEYS-1:0]   prev_q;
	logic [CW-1:0]          run_q;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_q <= '0;
			run_q  <= '0;
		end else begin
			prev_q <= keys;
			if (!one_hot) begin
				run_q <= '0;
			end else if (keys != prev_q) begin
				run_q <= CW'(1);
			end else if (run_q != CW'(DEB_CYC)) begin
				run_q <= run_q + 1'b1;
			end
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_DEBOUNCE: assert property ( // RQ13
		(|evt_q.press) |-> (run_q == CW'(DEB_CYC)))
		else $error("press recognised before full hold time");
	AST_CHORD: assert property ( // RQ16
		($countones(keys) > 1) |=> !(|evt_q.press))
		else $error("press accepted while several keys down");
	AST_SINGLE: assert property ( // RQ12
		$onehot0(evt_q.press) && $onehot0(evt_q.held))
		else $error("more than one key recognised");

endmodule

// *** verilog/fkl_retain.sv ***
// module: retained key state, restored or cleared after power-up
`timescale 1ns/10ps
module fkl_retain #(
	parameter int W = fkl_pkg::FKL_NKEYS
) (
	input  logic          aclk,
	input  logic          aresetn,
	input  logic          batt_ok,
	input  logic [W-1:0]  ret_in,
	input  logic [W-1:0]  state_in,
	output logic [W-1:0]  ret_out,
	output logic          ret_we,
	output logic          restore,
	output logic [W-1:0]  restore_data,
	output logic          batt_good
);
	import fkl_pkg::*;

	if (W < 1) begin : g_chk
		$error("fkl_retain: W must be at least 1");
	end

	logic           done_q;    // power-up sample taken
	logic           rest_q;    // restore pulse
	logic [W-1:0]   rdat_q;    // restored or cleared states
	logic           good_q;    // battery was valid at power-up
	logic [W-1:0]   out_q;     // copy towards backed store
	logic           we_q;      // store write enable

	assign ret_out      = out_q;
	assign ret_we       = we_q;
	assign restore      = rest_q;
	assign restore_data = rdat_q;
	assign batt_good    = good_q;

	// one sample of battery and store right after reset release
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_q <= 1'b0;
			rest_q <= 1'b0;
			rdat_q <= '0;
			good_q <= 1'b0;
		end else if (!done_q) begin
			done_q <= 1'b1;
			rest_q <= 1'b1;
			good_q <= batt_ok;                  // RQ17
			rdat_q <= batt_ok ? ret_in : '0;    // RQ10 RQ11
		end else begin
			rest_q <= 1'b0;
		end
	end

	// mirror live states into the store once restore has landed
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			out_q <= '0;
			we_q  <= 1'b0;
		end else begin
			out_q <= state_in;                  // RQ10
			we_q  <= done_q && !rest_q;
		end
	end

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_FLAT_CLEAR: assert property ( // RQ11
		rest_q && !good_q |-> (rdat_q == '0))
		else $error("states not cleared with flat battery");
	AST_RESTORE: assert property ( // RQ10
		rest_q && good_q |-> (rdat_q == $past(ret_in)))
		else $error("restored states differ from store");

endmodule

// *** verilog/fkl_top.sv ***
// module: function key logic with its AXI4-Lite register file
//
// Behaviour
// RQ1: ten keys, states readable as 10-bit word
// RQ2: each key drives one scheme logic output
// RQ3: per-key mode: latching or momentary
// RQ4: latching: press sets, next press clears
// RQ5: momentary: output follows recognised press
// RQ6: disabled key never asserts its output
// RQ7: locked key ignores all further presses
// RQ8: locked latching key holds its set output
// RQ9: locked momentary key output forced off
// RQ10: key states retained and restored at power-up
// RQ11: flat or missing battery clears all outputs
// RQ12: only one key press accepted at once
// RQ13: press counts only after 200 ms hold
// RQ14: optional minimum pulse stretch per output
// RQ15: per-key tri-colour indicator shows activation
// RQ16: chorded keys ignored until all released
// RQ17: battery-valid input sampled at power-up
`timescale 1ns/10ps
module fkl_top #(
	parameter int DEB_CYC = fkl_pkg::FKL_DEB_CYC,
	parameter int MS_CYC  = fkl_pkg::FKL_MS_CYC
) (
	input  logic                            aclk,
	input  logic                            aresetn,
	input  logic [7:0]                      s_axi_awaddr,
	input  logic                            s_axi_awvalid,
	output logic                            s_axi_awready,
	input  logic [31:0]                     s_axi_wdata,
	input  logic [3:0]                      s_axi_wstrb,
	input  logic                            s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  logic                            s_axi_bready,
	input  logic [7:0]                      s_axi_araddr,
	input  logic                            s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  logic                            s_axi_rready,
	input  logic [fkl_pkg::FKL_NKEYS-1:0]   key_press,
	input  logic                            batt_ok,
	input  logic [fkl_pkg::FKL_NKEYS-1:0]   ret_data_in,
	output logic [fkl_pkg::FKL_NKEYS-1:0]   ret_data_out,
	output logic                            ret_write,
	output logic [fkl_pkg::FKL_NKEYS-1:0]   scheme_logic_signal,
	output logic [fkl_pkg::FKL_NKEYS-1:0]   led_red,
	output logic [fkl_pkg::FKL_NKEYS-1:0]   led_green
);
	import fkl_pkg::*;

	localparam int MW = $clog2(MS_CYC + 1);  // ms divider width
	localparam int N  = FKL_NKEYS;

	// refuse a millisecond divider that cannot tick
	if (MS_CYC < 1) begin : g_chk
		$error("fkl_top: MS_CYC must be at least 1");
	end

	// software settings
	logic [N-1:0]            mode_q;   // key_mode_setting, 1 = latching
	logic [2*N-1:0]          ena_q;    // key_enable_setting, 2 bits a key
	logic [N-1:0]            pen_q;    // pulse stretch enables
	logic [FKL_PLEN_W-1:0]   plen_q;   // stretch length in ms
	logic [2*N-1:0]          led_q;    // colour: bit0 red, bit1 green

	// bus slave state
	logic                    awrdy_q;  // write address ready
	logic                    wrdy_q;   // write data ready
	logic                    aw_got_q; // address held
	logic                    w_got_q;  // data held
	logic [7:0]              waddr_q;  // held write address
	logic [31:0]             wdata_q;  // held write data
	logic [3:0]              wstrb_q;  // held byte strobes
	logic                    bvalid_q; // write answer
	logic [1:0]              bresp_q;
	logic                    arrdy_q;  // read address ready
	logic                    rvalid_q; // read answer
	logic [31:0]             rdata_q;
	logic [1:0]              rresp_q;
	logic                    wr_go;    // both halves of a write held
	logic [31:0]             wmask;    // byte-lane mask
	logic [7:0]              wa;       // aligned write address
	logic [7:0]              ra;       // aligned read address
	logic                    wr_hit;   // write address mapped
	logic [31:0]             rd_d;     // read mux
	logic                    rd_hit;   // read address mapped

	// key channel state
	fkl_key_evt_t            evt;      // recognised key events
	logic                    restore;  // power-up restore pulse
	logic [N-1:0]            rest_dat; // restored states
	logic                    batt_good;
	logic [N-1:0]            latch_q;  // latching state per key
	logic [N-1:0]            raw;      // unstretched output level
	logic [N-1:0]            raw_q;    // for rise detection
	logic [N-1:0]            out_q;    // key outputs
	logic [N-1:0]            red_q;
	logic [N-1:0]            green_q;
	logic [MW-1:0]           ms_cnt_q; // millisecond divider
	logic                    ms_tick_q;

	assign s_axi_awready       = awrdy_q;
	assign s_axi_wready        = wrdy_q;
	assign s_axi_bvalid        = bvalid_q;
	assign s_axi_bresp         = bresp_q;
	assign s_axi_arready       = arrdy_q;
	assign s_axi_rvalid        = rvalid_q;
	assign s_axi_rdata         = rdata_q;
	assign s_axi_rresp         = rresp_q;
	assign scheme_logic_signal = out_q;   // RQ2
	assign led_red             = red_q;
	assign led_green           = green_q;

	assign wr_go = aw_got_q && w_got_q && !bvalid_q;
	assign wa    = waddr_q & FKL_ADDR_MASK;
	assign ra    = s_axi_araddr & FKL_ADDR_MASK;
	assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
	                {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

	// write address and data taken in either order
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awrdy_q  <= 1'b1;
			wrdy_q   <= 1'b1;
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			waddr_q  <= 8'h00;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else begin
			if (s_axi_awvalid && awrdy_q) begin
				waddr_q  <= s_axi_awaddr;
				aw_got_q <= 1'b1;
				awrdy_q  <= 1'b0;
			end
			if (s_axi_wvalid && wrdy_q) begin
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
				w_got_q <= 1'b1;
				wrdy_q  <= 1'b0;
			end
			// consume the pair, reopen after the answer is taken
			if (wr_go) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
			end
			if (bvalid_q && s_axi_bready) begin
				awrdy_q <= 1'b1;
				wrdy_q  <= 1'b1;
			end
		end
	end

	// write decode, unknown words answer with an error
	always_comb begin
		case (wa)
			FKL_OFF_MODE, FKL_OFF_ENABLE, FKL_OFF_PEN,
			FKL_OFF_PLEN, FKL_OFF_LED, FKL_OFF_STATE,
			FKL_OFF_INFO: wr_hit = 1'b1;
			default:      wr_hit = 1'b0;
		endcase
	end

	// write answer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q  <= FKL_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? FKL_RESP_OKAY : FKL_RESP_SLVERR;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// settings registers, byte lanes honoured
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= FKL_MODE_RST;
			ena_q  <= FKL_ENA_RST;
			pen_q  <= FKL_PEN_RST;
			plen_q <= FKL_PLEN_RST;
			led_q  <= FKL_LED_RST;
		end else if (wr_go) begin
			case (wa)
				FKL_OFF_MODE: begin // RQ3
					mode_q <= (mode_q & ~wmask[N-1:0])
					        | (wdata_q[N-1:0] & wmask[N-1:0]);
				end
				FKL_OFF_ENABLE: begin // RQ6
					ena_q <= (ena_q & ~wmask[2*N-1:0])
					       | (wdata_q[2*N-1:0] & wmask[2*N-1:0]);
				end
				FKL_OFF_PEN: begin // RQ14
					pen_q <= (pen_q & ~wmask[N-1:0])
					       | (wdata_q[N-1:0] & wmask[N-1:0]);
				end
				FKL_OFF_PLEN: begin
					plen_q <= (plen_q & ~wmask[FKL_PLEN_W-1:0])
					        | (wdata_q[FKL_PLEN_W-1:0]
					        & wmask[FKL_PLEN_W-1:0]);
				end
				FKL_OFF_LED: begin // RQ15
					led_q <= (led_q & ~wmask[2*N-1:0])
					       | (wdata_q[2*N-1:0] & wmask[2*N-1:0]);
				end
				default: begin
					// read-only or unmapped: nothing stored
				end
			endcase
		end
	end

	// read mux, unused upper bits read zero
	always_comb begin
		rd_hit = 1'b1;
		case (ra)
			FKL_OFF_MODE:   rd_d = 32'(mode_q);
			FKL_OFF_ENABLE: rd_d = 32'(ena_q);
			FKL_OFF_PEN:    rd_d = 32'(pen_q);
			FKL_OFF_PLEN:   rd_d = 32'(plen_q);
			FKL_OFF_LED:    rd_d = 32'(led_q);
			FKL_OFF_STATE:  rd_d = 32'(out_q);      // RQ1
			FKL_OFF_INFO:   rd_d = 32'(batt_good);
			default: begin
				rd_d   = 32'h0000_0000;
				rd_hit = 1'b0;
			end
		endcase
	end

	// read channel, answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arrdy_q  <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= FKL_RESP_OKAY;
		end else if (s_axi_arvalid && arrdy_q) begin
			arrdy_q  <= 1'b0;
			rvalid_q <= 1'b1;
			rdata_q  <= rd_d;
			rresp_q  <= rd_hit ? FKL_RESP_OKAY : FKL_RESP_SLVERR;
		end else if (rvalid_q && s_axi_rready) begin
			arrdy_q  <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	// millisecond tick for pulse stretching
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ms_cnt_q  <= '0;
			ms_tick_q <= 1'b0;
		end else if (ms_cnt_q == MW'(MS_CYC - 1)) begin
			ms_cnt_q  <= '0;
			ms_tick_q <= 1'b1;
		end else begin
			ms_cnt_q  <= ms_cnt_q + 1'b1;
			ms_tick_q <= 1'b0;
		end
	end

	// pushbutton recogniser
	fkl_keyscan #(
		.DEB_CYC (DEB_CYC)
	) u_scan (
		.aclk    (aclk),
		.aresetn (aresetn),
		.keys    (key_press),
		.evt     (evt)
	);

	// retained storage of the latching states
	fkl_retain #(
		.W            (N)
	) u_retain (
		.aclk         (aclk),
		.aresetn      (aresetn),
		.batt_ok      (batt_ok),
		.ret_in       (ret_data_in),
		.state_in     (latch_q),
		.ret_out      (ret_data_out),
		.ret_we       (ret_write),
		.restore      (restore),
		.restore_data (rest_dat),
		.batt_good    (batt_good)
	);

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// one channel per key
	for (genvar k = 0; k < N; k++) begin : g_key
		logic                    ena;   // key enabled
		logic                    lck;   // key locked
		logic                    keep;  // stretch allowed
		logic [FKL_PLEN_W-1:0]   pcnt_q; // stretch remaining, ms

		assign ena  = (ena_q[2*k+1:2*k] == FKL_ENA);
		assign lck  = (ena_q[2*k+1:2*k] == FKL_LOCK);
		assign keep = pen_q[k] && (ena || (lck && mode_q[k]));
		// latching shows its state, momentary the held level
		assign raw[k] = mode_q[k] ? (latch_q[k] && (ena || lck)) // RQ8
		                          : (ena && evt.held[k]);  // RQ5 RQ9

		// latching state
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				latch_q[k] <= 1'b0;
			end else if (restore) begin
				latch_q[k] <= rest_dat[k];          // RQ10 RQ11
			end else if (lck) begin
				latch_q[k] <= latch_q[k];           // RQ7
			end else if (!ena) begin
				latch_q[k] <= 1'b0;                 // RQ6
			end else if (evt.press[k] && mode_q[k]) begin
				latch_q[k] <= !latch_q[k];          // RQ4
			end
		end

		// minimum pulse stretch
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pcnt_q <= '0;
			end else if (!keep) begin
				pcnt_q <= '0;
			end else if (raw[k] && !raw_q[k]) begin
				pcnt_q <= plen_q;                   // RQ14
			end else if (ms_tick_q && (pcnt_q != '0)) begin
				pcnt_q <= pcnt_q - 1'b1;
			end
		end

		// output and indicator
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				raw_q[k]   <= 1'b0;
				out_q[k]   <= 1'b0;
				red_q[k]   <= 1'b0;
				green_q[k] <= 1'b0;
			end else begin
				raw_q[k]   <= raw[k];
				out_q[k]   <= raw[k] || (keep && (pcnt_q != '0));
				red_q[k]   <= raw[k] && led_q[2*k];     // RQ15
				green_q[k] <= raw[k] && led_q[2*k+1];
			end
		end

		AST_DIS_OFF: assert property ( // RQ6
			(ena_q[2*k+1:2*k] == FKL_DIS)
			&& ($past(ena_q[2*k+1:2*k]) == FKL_DIS) |-> !out_q[k])
			else $error("disabled key output asserted");
		AST_LOCK_HOLD: assert property ( // RQ7
			lck && $past(lck) && !$past(restore)
			|-> (latch_q[k] == $past(latch_q[k])))
			else $error("locked key state changed");
		AST_LOCK_MOM: assert property ( // RQ9
			lck && !mode_q[k] && $past(lck) && !$past(mode_q[k])
			|-> !out_q[k])
			else $error("locked momentary key output active");
		AST_TOGGLE: assert property ( // RQ4
			evt.press[k] && ena && mode_q[k] && !restore
			|=> (latch_q[k] != $past(latch_q[k])))
			else $error("latching key did not toggle");
		AST_MOMENT: assert property ( // RQ5
			ena && !mode_q[k] && evt.held[k] |=> out_q[k])
			else $error("momentary key output not asserted");
		AST_STRETCH: assert property ( // RQ14
			raw[k] && !raw_q[k] && keep && (plen_q != '0)
			|=> out_q[k] && (pcnt_q != '0))
			else $error("pulse stretch not started");
	end

endmodule
